// ===== core/alu_exec_defs.svh
// Constants for the byte ALU and branch execution unit.
// Assumes inclusion by bare name from core sources.
`ifndef ALU_EXEC_DEFS_SVH
`define ALU_EXEC_DEFS_SVH
`define OPC_ADD_IMM 8'h0f
`define OPC_ADD_FILE 6'h09
`define OPC_AND_FILE 6'h05
`define OPC_BR_CARRY 8'he2
`define ACC_RESET 8'h00
`define BANK_RESET 4'h0
`define PC_RESET 21'h000000
`define PC_STEP 21'h000002
`define FLAG_NEG 4
`define FLAG_WRAP 3
`define FLAG_ZERO 2
`define FLAG_NIB 1
`define FLAG_CARRY 0
`define ACCESS_SPLIT 8'h80
`endif

// ===== core/alu_exec_pkg.sv
// Types shared by the execution unit files.
// Assumes alu_exec_defs.svh for the numeric constants.
package alu_exec_pkg;
    typedef enum logic [1:0]
    {
        ST_EXEC = 2'b00,
        ST_BUBBLE = 2'b01
    } exec_state_e;
    typedef enum logic [2:0]
    {
        OP_NONE = 3'b000,
        OP_ADD_IMM = 3'b001,
        OP_ADD_FILE = 3'b010,
        OP_AND_FILE = 3'b011,
        OP_BR_CARRY = 3'b100
    } op_kind_e;
endpackage : alu_exec_pkg

// ===== core/byte_alu.sv
// Combinational 8-bit adder and AND unit producing status flags.
// Assumes the caller registers the results.
`timescale 1ns/1ns
`include "alu_exec_defs.svh"
module byte_alu
    import alu_exec_pkg::*;
(
    // Operands
    input wire logic [7:0] opa,
    input wire logic [7:0] opb,
    input wire logic do_and,
    // Results
    output logic [7:0] result,
    output logic [4:0] flags,
    output logic [4:0] flag_mask
);
    logic [4:0] low_sum;
    logic [8:0] sum;
    always_comb
    begin
        low_sum = {1'b0, opa[3:0]} + {1'b0, opb[3:0]};
        sum = {1'b0, opa} + {1'b0, opb};
        flags = 5'h00;
        if (do_and)
        begin
            result = opa & opb;
            flag_mask = 5'h14; // RULE_04
        end
        else
        begin
            result = sum[7:0];
            flag_mask = 5'h1f; // RULE_06
            flags[`FLAG_CARRY] = sum[8]; // RULE_06
            flags[`FLAG_NIB] = low_sum[4]; // RULE_06
            flags[`FLAG_WRAP] = (opa[7] == opb[7]) && (sum[7] != opa[7]);
        end
        flags[`FLAG_NEG] = result[7];
        flags[`FLAG_ZERO] = (result == 8'h00);
    end
endmodule : byte_alu

// ===== core/byte_alu_branch_exec.sv
// Executes add_immediate, add_to_file, and_with_file, branch_if_carry.
// Assumes a fetched 16-bit word per enabled cycle and a combinational file
// read port; the file write lands in the same cycle as the result.
// Function
// RULE_01: add_immediate adds literal into accumulator
// RULE_02: add_to_file sums, destination bit picks target
// RULE_03: access bit picks access bank or bank_pointer
// RULE_04: and_with_file ANDs, updates negative, zero only
// RULE_05: branch_if_carry jumps PC+2+2n, two cycles
// RULE_06: adds set five flags from sum
`timescale 1ns/1ns
`include "alu_exec_defs.svh"
module byte_alu_branch_exec
    import alu_exec_pkg::*;
#(
    parameter int PC_W = 21
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clk_en,
    // Instruction
    input wire logic [15:0] instr,
    input wire logic instr_valid,
    // Bank pointer load
    input wire logic bank_wr,
    input wire logic [3:0] bank_wdata,
    // File register read data for file_addr
    input wire logic [7:0] file_rdata,
    // File register access
    output logic [11:0] file_addr,
    output logic file_we,
    output logic [7:0] file_wdata,
    // Core state
    output logic [7:0] accumulator,
    output logic [4:0] status,
    output logic [PC_W-1:0] pc,
    output logic busy
);
    exec_state_e state;
    op_kind_e kind;
    logic [3:0] bank_pointer;
    logic [7:0] alu_b;
    logic [7:0] alu_res;
    logic [4:0] alu_flags;
    logic [4:0] alu_mask;
    logic [PC_W-1:0] next_pc;
    logic [PC_W-1:0] offset2;

    always_comb
    begin
        kind = OP_NONE;
        if (instr[15:8] == `OPC_ADD_IMM)
            kind = OP_ADD_IMM;
        else if (instr[15:10] == `OPC_ADD_FILE)
            kind = OP_ADD_FILE;
        else if (instr[15:10] == `OPC_AND_FILE)
            kind = OP_AND_FILE;
        else if (instr[15:8] == `OPC_BR_CARRY)
            kind = OP_BR_CARRY;
    end

    // Operand b is the literal for add_immediate, else the file value.
    assign alu_b = (kind == OP_ADD_IMM) ? instr[7:0] : file_rdata; // RULE_01

    byte_alu u_alu
    (
        .opa(accumulator),
        .opb(alu_b),
        .do_and(kind == OP_AND_FILE),
        .result(alu_res),
        .flags(alu_flags),
        .flag_mask(alu_mask)
    );

    // Sign-extended 2n offset for the branch.
    assign offset2 = {{(PC_W-9){instr[7]}}, instr[7:0], 1'b0};
    assign next_pc = pc + `PC_STEP + offset2; // RULE_05

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            bank_pointer <= `BANK_RESET;
        else if (clk_en && bank_wr)
            bank_pointer <= bank_wdata;
    end

    // Access bank splits into low general RAM and high special registers.
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            file_addr <= 12'h000;
        else if (clk_en)
        begin
            if (instr[8])
                file_addr <= {bank_pointer, instr[7:0]}; // RULE_03
            else if (instr[7:0] < `ACCESS_SPLIT)
                file_addr <= {4'h0, instr[7:0]}; // RULE_03
            else
                file_addr <= {4'hf, instr[7:0]}; // RULE_03
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            state <= ST_EXEC;
        else if (clk_en)
        begin
            case (state)
                ST_EXEC:
                    if (instr_valid && kind == OP_BR_CARRY &&
                        status[`FLAG_CARRY])
                        state <= ST_BUBBLE; // RULE_05
                ST_BUBBLE:
                    state <= ST_EXEC;
                default:
                    state <= ST_EXEC;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            busy <= 1'b0;
        else if (clk_en)
            busy <= (state == ST_EXEC) && instr_valid &&
                (kind == OP_BR_CARRY) && status[`FLAG_CARRY];
    end

    logic fire;
    assign fire = clk_en && instr_valid && (state == ST_EXEC);

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            pc <= `PC_RESET;
        else if (fire)
        begin
            if (kind == OP_BR_CARRY && status[`FLAG_CARRY])
                pc <= next_pc; // RULE_05
            else
                pc <= pc + `PC_STEP;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            accumulator <= `ACC_RESET;
        else if (fire)
        begin
            if (kind == OP_ADD_IMM)
                accumulator <= alu_res; // RULE_01
            else if ((kind == OP_ADD_FILE || kind == OP_AND_FILE) &&
                !instr[9])
                accumulator <= alu_res; // RULE_02
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            file_we <= 1'b0;
            file_wdata <= 8'h00;
        end
        else if (clk_en)
        begin
            file_we <= fire && instr[9] &&
                (kind == OP_ADD_FILE || kind == OP_AND_FILE); // RULE_02
            file_wdata <= alu_res;
        end
    end

    // Only flags named by the ALU mask change; the branch touches none.
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            status <= 5'h00;
        else if (fire && kind != OP_NONE && kind != OP_BR_CARRY)
            status <= (status & ~alu_mask) | (alu_flags & alu_mask); // RULE_04
    end

    sequence br_taken_s;
        fire && kind == OP_BR_CARRY && status[`FLAG_CARRY];
    endsequence

    branch_target_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        br_taken_s |=> pc == $past(next_pc)) // RULE_05
        else $error("taken branch target wrong");
    branch_bubble_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        br_taken_s |=> state == ST_BUBBLE) // RULE_05
        else $error("taken branch lacks bubble cycle");
    branch_not_taken_a: assert property (@(posedge sys_clk)
        disable iff (!nrst)
        fire && kind == OP_BR_CARRY && !status[`FLAG_CARRY]
        |=> pc == $past(pc) + `PC_STEP && state == ST_EXEC) // RULE_05
        else $error("untaken branch wrong");
    add_imm_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        fire && kind == OP_ADD_IMM |=>
        accumulator == 8'($past(accumulator) + $past(instr[7:0]))) // RULE_01
        else $error("add_immediate sum wrong");
    add_file_dest_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        fire && kind == OP_ADD_FILE && instr[9] |=>
        file_we && accumulator == $past(accumulator)) // RULE_02
        else $error("add_to_file destination wrong");
    and_flags_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        fire && kind == OP_AND_FILE |=>
        status[`FLAG_CARRY] == $past(status[`FLAG_CARRY]) &&
        status[`FLAG_NIB] == $past(status[`FLAG_NIB])) // RULE_04
        else $error("and_with_file touched carry");
    bank_addr_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        clk_en && instr[8] |=>
        file_addr[11:8] == $past(bank_pointer)) // RULE_03
        else $error("banked address wrong");
    add_zero_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        fire && kind == OP_ADD_IMM |=>
        status[`FLAG_ZERO] == (accumulator == 8'h00)) // RULE_06
        else $error("zero flag wrong after add");
endmodule : byte_alu_branch_exec

// ===== dv/byte_alu_branch_exec_bench.sv
// Self-checking bench for the byte ALU and branch execution unit.
// Assumes a combinational file read, so file_rdata is driven with instr.
`timescale 1ns/1ns
module byte_alu_branch_exec_bench;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic clk_en = 1'b1;
    logic [15:0] instr = 16'h0000;
    logic instr_valid = 1'b0;
    logic bank_wr = 1'b0;
    logic [3:0] bank_wdata = 4'h0;
    logic [7:0] file_rdata = 8'h00;
    logic [11:0] file_addr;
    logic file_we;
    logic [7:0] file_wdata;
    logic [7:0] accumulator;
    logic [4:0] status;
    logic [20:0] pc;
    logic busy;
    logic [20:0] exp_pc = 21'h000000;
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;

    byte_alu_branch_exec #(.PC_W(21)) i_byte_alu_branch_exec
    (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .clk_en(clk_en),
        .instr(instr),
        .instr_valid(instr_valid),
        .bank_wr(bank_wr),
        .bank_wdata(bank_wdata),
        .file_rdata(file_rdata),
        .file_addr(file_addr),
        .file_we(file_we),
        .file_wdata(file_wdata),
        .accumulator(accumulator),
        .status(status),
        .pc(pc),
        .busy(busy)
    );

    always #4 sys_clk = ~sys_clk;

    // The whole run is well under a hundred cycles.
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            mismatches++;
            results();
        end
    end

    task chk(input string name, input logic [20:0] exp,
             input logic [20:0] got);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Entered just after an edge; returns just after the executing edge.
    task run(input logic [15:0] word, input logic [7:0] rd);
        instr = word;
        instr_valid = 1'b1;
        file_rdata = rd;
        @(posedge sys_clk);
        #1;
        exp_pc = exp_pc + 21'h2;
    endtask : run

    task test_add_imm;
        run(16'h0f10, 8'h00);
        run(16'h0f15, 8'h00);
        chk("acc", 21'h25, 21'(accumulator));
        chk("status", 21'h00, 21'(status));
        run(16'h0fdb, 8'h00);
        chk("acc", 21'h00, 21'(accumulator));
        chk("status", 21'h07, 21'(status));
        run(16'h0f7f, 8'h00);
        run(16'h0f01, 8'h00);
        chk("status", 21'h1a, 21'(status));
        run(16'h0f97, 8'h00);
        chk("acc", 21'h17, 21'(accumulator));
        chk("status", 21'h09, 21'(status));
    endtask : test_add_imm

    task test_add_file;
        run(16'h2410, 8'hc2);
        chk("acc", 21'hd9, 21'(accumulator));
        chk("status", 21'h10, 21'(status));
        chk("addr", 21'h010, 21'(file_addr));
        chk("we", 21'h0, 21'(file_we));
        bank_wr = 1'b1;
        bank_wdata = 4'h3;
        instr_valid = 1'b0;
        @(posedge sys_clk);
        #1;
        bank_wr = 1'b0;
        run(16'h2720, 8'h27);
        chk("we", 21'h1, 21'(file_we));
        chk("wdata", 21'h00, 21'(file_wdata));
        chk("addr", 21'h320, 21'(file_addr));
        chk("acc", 21'hd9, 21'(accumulator));
        chk("status", 21'h07, 21'(status));
    endtask : test_add_file

    task test_and_file;
        run(16'h1490, 8'h80);
        chk("acc", 21'h80, 21'(accumulator));
        chk("status", 21'h13, 21'(status));
        chk("addr", 21'hf90, 21'(file_addr));
        chk("we", 21'h0, 21'(file_we));
        run(16'h1705, 8'h0f);
        chk("we", 21'h1, 21'(file_we));
        chk("wdata", 21'h00, 21'(file_wdata));
        chk("status", 21'h07, 21'(status));
        chk("acc", 21'h80, 21'(accumulator));
    endtask : test_and_file

    task test_branch;
        run(16'he2fe, 8'h00);
        exp_pc = exp_pc - 21'h4;
        chk("pc", exp_pc, pc);
        chk("busy", 21'h1, 21'(busy));
        // An instruction offered in the bubble must be dropped.
        run(16'h0f01, 8'h00);
        exp_pc = exp_pc - 21'h2;
        chk("acc", 21'h80, 21'(accumulator));
        chk("pc", exp_pc, pc);
        chk("busy", 21'h0, 21'(busy));
        run(16'h0f00, 8'h00);
        run(16'he205, 8'h00);
        chk("pc", exp_pc, pc);
        chk("busy", 21'h0, 21'(busy));
        run(16'h0f80, 8'h00);
        run(16'he27f, 8'h00);
        exp_pc = exp_pc + 21'd254;
        chk("pc", exp_pc, pc);
        chk("busy", 21'h1, 21'(busy));
    endtask : test_branch

    // Clock enable low must hold every register, the bubble state too;
    // a reset in mid-run must then clear all outputs at once.
    task test_freeze_reset;
        clk_en = 1'b0;
        run(16'h0f01, 8'h00);
        exp_pc = exp_pc - 21'h2;
        chk("busy", 21'h1, 21'(busy));
        clk_en = 1'b1;
        run(16'h0f01, 8'h00);
        exp_pc = exp_pc - 21'h2;
        chk("busy", 21'h0, 21'(busy));
        clk_en = 1'b0;
        run(16'h0f01, 8'h00);
        exp_pc = exp_pc - 21'h2;
        chk("acc", 21'h00, 21'(accumulator));
        chk("pc", exp_pc, pc);
        chk("status", 21'h0d, 21'(status));
        clk_en = 1'b1;
        nrst = 1'b0;
        #1;
        chk("status", 21'h00, 21'(status));
        chk("pc", 21'h0, pc);
        chk("addr", 21'h000, 21'(file_addr));
        @(posedge sys_clk);
        #1;
        nrst = 1'b1;
        exp_pc = 21'h0;
        run(16'h0f05, 8'h00);
        chk("acc", 21'h05, 21'(accumulator));
        chk("pc", exp_pc, pc);
    endtask : test_freeze_reset

    task results;
        if (mismatches == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : results

    initial
    begin
        repeat (4) @(posedge sys_clk);
        #1;
        nrst = 1'b1;
        chk("pc", 21'h0, pc);
        chk("acc", 21'h0, 21'(accumulator));
        test_add_imm();
        test_add_file();
        test_and_file();
        test_branch();
        test_freeze_reset();
        results();
    end
endmodule : byte_alu_branch_exec_bench
